// ===== shared/ses_pkg.sv
// Constants for the receiver eye-scan and equalizer analysis block
package ses_pkg;
	localparam int LANES_DEF = 4;
	localparam logic [3:0] AUTO_MODE_MIN = 4'h8;
	localparam logic [3:0] MODE_INNER = 4'h8;
	localparam logic [3:0] MODE_OUTER = 4'h9;
	localparam logic [3:0] MODE_AVG = 4'ha;
	localparam logic [3:0] MODE_MATCH = 4'h1;
	localparam logic [4:0] DECIM_LAST = 5'h13;
	localparam logic [1:0] EQ_ADAPT = 2'h1;
	localparam logic [1:0] EQ_PRE = 2'h2;
	localparam logic [1:0] EQ_POST = 2'h3;
	localparam int HOLD_UI = 48;
	localparam int ANALYSIS_UI = 150000;
	localparam logic [5:0] HOLD_CYC = 6'(HOLD_UI - 1);
	localparam logic [17:0] ANALYSIS_CYC = 18'(ANALYSIS_UI - 1);
	localparam logic [15:0] TALLY_RST = 16'h0000;
	localparam logic [5:0] LEVEL_RST = 6'h20;
	localparam logic [5:0] LEVEL_MAX = 6'h3f;
	typedef enum logic [1:0] {SES_IDLE, SES_RUN, SES_DONE} ses_state_type;
endpackage

// ===== logic/ses_top.sv
// Per-lane eye-scan engine with equalizer hold and cursor analysis
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Every enabled lane scans concurrently from its own received bitstream.
// - Modes below 8 use programmed voltage offset; higher modes sweep it automatically.
// - Only one of twenty bits is examined; pick selects phase 0 to 19.
// - Scan length sets how many decimated bits one run analyses.
// - Clear pulse high then low zeros tally; otherwise tally accumulates across runs.
// - Run high starts a scan after configuration is set.
// - Each lane raises its own done flag when its run finishes.
// - Inner, outer, average modes report boundary; other modes report tally.
// - Run returns low between scans; link may stay enabled throughout.
// - Equalizer mode 1 with link enabled adapts continuously; level readable.
// - Freeze stops adaptation and forces over and under flags low.
// - Freeze changes take effect within 48 unit intervals of recovery activity.
// - Under freeze choose mode 2 or 3, release freeze; analysis keeps response frozen.
// - Cursor analysis completes within 150000 unit intervals of recovery activity.
// - At analysis end raise over flag or under flag per result.
// - Mode 1 then freeze release resumes normal adaptation.
module ses_top #(
	parameter int LANES = ses_pkg::LANES_DEF,
	parameter int LEN_W = 16,
	parameter logic [17:0] ANALYSIS_COUNT = ses_pkg::ANALYSIS_CYC
)(
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire logic               link_receiver_enable,
	input  wire logic [LANES-1:0]   lane_enable,
	input  wire logic [LANES-1:0]   lane_bit,
	input  wire logic [LANES-1:0]   lane_bit_valid,
	input  wire logic [LANES-1:0]   lane_sample_bit,
	input  wire logic [LANES-1:0]   lane_early,
	input  wire logic [LANES-1:0]   lane_late,
	input  wire logic [3:0]         scan_mode_select,
	input  wire logic [5:0]         sampler_voltage_offset,
	input  wire logic [5:0]         sampler_phase_offset,
	input  wire logic [4:0]         decimation_phase_pick,
	input  wire logic [LEN_W-1:0]   scan_length,
	input  wire logic               tally_clear,
	input  wire logic               scan_run,
	input  wire logic [1:0]         equalizer_mode,
	input  wire logic               equalizer_freeze,
	output logic [5:0]              sampler_voltage_drive,
	output logic [5:0]              sampler_phase_drive,
	output logic [LANES-1:0]        scan_done_per_lane,
	output logic [LANES*16-1:0]     mismatch_tally,
	output logic [LANES*6-1:0]      boundary_result,
	output logic [5:0]              equalizer_level_readback,
	output logic                    over_equalized_flag,
	output logic                    under_equalized_flag
);
	logic        clr_d_r;
	logic        clr_pulse;
	logic        run_d_r;
	logic        run_start;
	logic        auto_mode;
	logic        hold_eff_r;
	logic [5:0]  hold_cnt_r;
	logic [17:0] an_cnt_r;
	logic        an_active_r;
	logic        an_done_r;
	logic [15:0] pre_score_r;
	logic        freeze_d_r;

	function automatic logic is_boundary_mode(input logic [3:0] m);
		is_boundary_mode = (m == ses_pkg::MODE_INNER) || (m == ses_pkg::MODE_OUTER)
			|| (m == ses_pkg::MODE_AVG);
	endfunction

	// Tally clears on the falling edge of the clear control
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clr_d_r <= 1'b0;
			run_d_r <= 1'b0;
		end
		else
		begin
			clr_d_r <= tally_clear;
			run_d_r <= scan_run;
		end
	end
	assign clr_pulse = clr_d_r && !tally_clear;
	assign run_start = scan_run && !run_d_r && link_receiver_enable;
	assign auto_mode = (scan_mode_select >= ses_pkg::AUTO_MODE_MIN);
	assign sampler_phase_drive = sampler_phase_offset;

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : lane
			ses_pkg::ses_state_type st_r;
			logic [4:0]       ph_r;
			logic [LEN_W-1:0] len_r;
			logic [15:0]      tally_r;
			logic [5:0]       vo_r;
			logic [5:0]       bnd_r;
			logic             take;
			logic             miss;
			assign take = (st_r == ses_pkg::SES_RUN) && lane_bit_valid[g]
				&& (ph_r == decimation_phase_pick);
			// Match-counting mode inverts the comparison
			assign miss = (scan_mode_select == ses_pkg::MODE_MATCH) ?
				(lane_sample_bit[g] == lane_bit[g]) : (lane_sample_bit[g] != lane_bit[g]);

			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
					ph_r <= 5'h00;
				else if (!link_receiver_enable || !lane_enable[g])
					ph_r <= 5'h00;
				else if (lane_bit_valid[g])
					ph_r <= (ph_r == ses_pkg::DECIM_LAST) ? 5'h00 : ph_r + 5'h01;
			end

			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					st_r <= ses_pkg::SES_IDLE;
					len_r <= '0;
				end
				else if (!scan_run || !link_receiver_enable)
					st_r <= ses_pkg::SES_IDLE;
				else
				begin
					unique case (st_r)
						ses_pkg::SES_IDLE:
							if (run_start && lane_enable[g])
							begin
								st_r <= ses_pkg::SES_RUN;
								len_r <= '0;
							end
						ses_pkg::SES_RUN:
							if (take)
							begin
								len_r <= len_r + 1'b1;
								if (len_r + 1'b1 >= scan_length)
									st_r <= ses_pkg::SES_DONE;
							end
						ses_pkg::SES_DONE:
							st_r <= ses_pkg::SES_DONE;
					endcase
				end
			end
			assign scan_done_per_lane[g] = (st_r == ses_pkg::SES_DONE);

			// Tally saturates rather than wrap, so long runs stay monotonic
			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
					tally_r <= ses_pkg::TALLY_RST;
				else if (clr_pulse)
					tally_r <= ses_pkg::TALLY_RST;
				else if (take && miss && !is_boundary_mode(scan_mode_select) && ~&tally_r)
					tally_r <= tally_r + 16'h0001;
			end

			// Auto sweep: step offset toward the eye edge on each matching decimated sample; a mismatch records the boundary
			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					vo_r <= 6'h00;
					bnd_r <= 6'h00;
				end
				else if (run_start)
					vo_r <= auto_mode ? ses_pkg::LEVEL_RST : sampler_voltage_offset;
				else if (take && auto_mode)
				begin
					if (miss)
						bnd_r <= vo_r;
					else if (vo_r != ses_pkg::LEVEL_MAX)
						vo_r <= vo_r + 6'h01;
				end
				else if (!auto_mode)
					vo_r <= sampler_voltage_offset;
			end
			assign mismatch_tally[g*16 +: 16] = tally_r;
			assign boundary_result[g*6 +: 6] = bnd_r;

			a_tally_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
				clr_pulse |=> tally_r == ses_pkg::TALLY_RST)
				else $error("tally not cleared");
			a_done_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
				!scan_run |=> !scan_done_per_lane[g])
				else $error("done flag survives run low");
			a_done_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
				scan_done_per_lane[g] && scan_run && link_receiver_enable
				|=> scan_done_per_lane[g])
				else $error("done flag dropped");
			a_decim_take: assert property (@(posedge ref_clk) disable iff (!resetn)
				take |=> !take [*8])
				else $error("decimated samples too close");
		end
	endgenerate

	assign sampler_voltage_drive = auto_mode ? lane[0].vo_r : sampler_voltage_offset;

	// A freeze change takes effect only after it persists for a whole hold window, to mirror recovery latency
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hold_cnt_r <= 6'h00;
			hold_eff_r <= 1'b0;
		end
		else if (equalizer_freeze == hold_eff_r)
			hold_cnt_r <= 6'h00;
		else if (hold_cnt_r == ses_pkg::HOLD_CYC)
		begin
			hold_eff_r <= equalizer_freeze;
			hold_cnt_r <= 6'h00;
		end
		else
			hold_cnt_r <= hold_cnt_r + 6'h01;
	end

	// Adaptation from early/late votes of lane 0
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			equalizer_level_readback <= ses_pkg::LEVEL_RST;
		else if (link_receiver_enable && !hold_eff_r && !an_active_r && !an_done_r
			&& equalizer_mode == ses_pkg::EQ_ADAPT)
		begin
			if (lane_late[0] && equalizer_level_readback != ses_pkg::LEVEL_MAX)
				equalizer_level_readback <= equalizer_level_readback + 6'h01;
			else if (lane_early[0] && equalizer_level_readback != 6'h00)
				equalizer_level_readback <= equalizer_level_readback - 6'h01;
		end
	end

	// Cursor analysis: start on release of freeze with mode 2 or 3
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			freeze_d_r <= 1'b0;
			an_active_r <= 1'b0;
			an_done_r <= 1'b0;
			an_cnt_r <= 18'h00000;
			pre_score_r <= 16'h0000;
		end
		else
		begin
			freeze_d_r <= hold_eff_r;
			if (hold_eff_r || equalizer_mode == ses_pkg::EQ_ADAPT || !link_receiver_enable)
			begin
				an_active_r <= 1'b0;
				an_done_r <= 1'b0;
			end
			else if (freeze_d_r && (equalizer_mode == ses_pkg::EQ_PRE
				|| equalizer_mode == ses_pkg::EQ_POST))
			begin
				an_active_r <= 1'b1;
				an_cnt_r <= 18'h00000;
				pre_score_r <= 16'h8000;
			end
			else if (an_active_r)
			begin
				if (lane_late[0] && !(&pre_score_r))
					pre_score_r <= pre_score_r + 16'h0001;
				else if (lane_early[0] && |pre_score_r)
					pre_score_r <= pre_score_r - 16'h0001;
				if (an_cnt_r == ANALYSIS_COUNT)
				begin
					an_active_r <= 1'b0;
					an_done_r <= 1'b1;
				end
				else
					an_cnt_r <= an_cnt_r + 18'h00001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			over_equalized_flag <= 1'b0;
			under_equalized_flag <= 1'b0;
		end
		else if (hold_eff_r || !an_done_r)
		begin
			over_equalized_flag <= 1'b0;
			under_equalized_flag <= 1'b0;
		end
		else
		begin
			over_equalized_flag <= pre_score_r < 16'h8000;
			under_equalized_flag <= pre_score_r > 16'h8000;
		end
	end

	a_freeze_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
		hold_eff_r |=> !over_equalized_flag && !under_equalized_flag)
		else $error("flags high under freeze");
	a_freeze_lvl: assert property (@(posedge ref_clk) disable iff (!resetn)
		hold_eff_r && $past(hold_eff_r) |-> $stable(equalizer_level_readback))
		else $error("level moved under freeze");
	a_hold_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(equalizer_freeze) |-> ##[1:49] (hold_eff_r || !equalizer_freeze))
		else $error("hold latency exceeded");
	a_flags_excl: assert property (@(posedge ref_clk) disable iff (!resetn)
		!(over_equalized_flag && under_equalized_flag))
		else $error("both flags high");
endmodule
`default_nettype wire

// ===== tb/ses_lane_tx.sv
// Remote lane transmitter model: recovered bits, sampler bits and votes
`timescale 1ns/1ps
`default_nettype none
module ses_lane_tx #(
	parameter int LANES = 2
)(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        miss_en,
	input  wire logic        vote_early,
	output logic [LANES-1:0] lane_bit,
	output logic [LANES-1:0] lane_bit_valid,
	output logic [LANES-1:0] lane_sample_bit,
	output logic [LANES-1:0] lane_early,
	output logic [LANES-1:0] lane_late
);
	logic [6:0] lfsr_r;
	// Generic pseudo-random stimulus, one bit per unit interval
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			lfsr_r <= 7'h5a;
		else
			lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
	end
	assign lane_bit = {LANES{lfsr_r[0]}};
	assign lane_bit_valid = {LANES{resetn}};
	// Sampler disagrees on every bit when a miss is injected
	assign lane_sample_bit = lane_bit ^ {LANES{miss_en}};
	assign lane_early = {LANES{vote_early}};
	assign lane_late = ~lane_early;
endmodule
`default_nettype wire

// ===== tb/ses_top_bench.sv
// Self-checking bench for the eye-scan and equalizer analysis block
`timescale 1ns/1ps
`default_nettype none
module ses_top_bench;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic link = 1'b0;
	logic [1:0] lane_en = 2'h3;
	logic [3:0] mode = 4'h0;
	logic [15:0] len = 16'h0003;
	logic clr = 1'b0;
	logic run = 1'b0;
	logic [1:0] eqm = 2'h1;
	logic frz = 1'b0;
	logic miss = 1'b1;
	logic early = 1'b1;
	logic [5:0] voff = 6'h15;
	logic [5:0] poff = 6'h0a;
	logic [4:0] pick = 5'h13;
	logic [1:0] bit_w, val_w, smp_w, ea_w, la_w, done;
	logic [5:0] vdrv, pdrv, lvl, keep;
	logic [31:0] tally;
	logic [11:0] bnd;
	logic ovr, und;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	always #5 ref_clk = ~ref_clk;
	ses_lane_tx #(.LANES(2)) tx (.ref_clk(ref_clk), .resetn(resetn), .miss_en(miss),
		.vote_early(early), .lane_bit(bit_w), .lane_bit_valid(val_w),
		.lane_sample_bit(smp_w), .lane_early(ea_w), .lane_late(la_w));
	// Short analysis count keeps the run brief
	ses_top #(.LANES(2), .LEN_W(16), .ANALYSIS_COUNT(18'h00032)) DUT (.ref_clk(ref_clk),
		.resetn(resetn), .link_receiver_enable(link), .lane_enable(lane_en),
		.lane_bit(bit_w), .lane_bit_valid(val_w), .lane_sample_bit(smp_w),
		.lane_early(ea_w), .lane_late(la_w), .scan_mode_select(mode),
		.sampler_voltage_offset(voff), .sampler_phase_offset(poff),
		.decimation_phase_pick(pick), .scan_length(len), .tally_clear(clr),
		.scan_run(run), .equalizer_mode(eqm), .equalizer_freeze(frz),
		.sampler_voltage_drive(vdrv), .sampler_phase_drive(pdrv),
		.scan_done_per_lane(done), .mismatch_tally(tally), .boundary_result(bnd),
		.equalizer_level_readback(lvl), .over_equalized_flag(ovr),
		.under_equalized_flag(und));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Run stays high until stop_run; waits for every enabled lane
	task automatic scan(input logic [3:0] m, input logic [15:0] n);
		int k;
		@(posedge ref_clk);
		mode <= m;
		len <= n;
		@(posedge ref_clk);
		run <= 1'b1;
		k = 0;
		while (((done & lane_en) !== lane_en) && k < 3000)
		begin
			wait_cyc(1);
			k++;
		end
	endtask
	task automatic stop_run();
		@(posedge ref_clk);
		run <= 1'b0;
		wait_cyc(2);
	endtask
	task automatic clear_tally();
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		wait_cyc(2);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	initial
	begin
		wait_cyc(6);
		resetn <= 1'b1;
		wait_cyc(1);
		check({done, ovr, und}, 16'h0000);
		check(tally[15:0], 16'h0000);
		check(16'(lvl), 16'h0020);
		check(16'(vdrv), 16'h0015);
		check(16'(pdrv), 16'h000a);
		link <= 1'b1;
		voff <= 6'h2a;
		poff <= 6'h11;
		wait_cyc(1);
		check(16'(vdrv), 16'h002a);
		check(16'(pdrv), 16'h0011);
		$display("test reset done");
		scan(4'h0, 16'h0003);
		check(16'(done), 16'h0003);
		check(tally[15:0], 16'h0003);
		check(tally[31:16], 16'h0003);
		stop_run();
		check(16'(done), 16'h0000);
		scan(4'h0, 16'h0003);
		check(tally[15:0], 16'h0006);
		stop_run();
		clear_tally();
		check(tally[15:0], 16'h0000);
		miss <= 1'b0;
		scan(4'h1, 16'h0002);
		check(tally[31:16], 16'h0002);
		stop_run();
		$display("test scan done");
		lane_en <= 2'h1;
		pick <= 5'h00;
		scan(4'h0, 16'h0001);
		wait_cyc(60);
		check(16'(done), 16'h0001);
		stop_run();
		lane_en <= 2'h3;
		link <= 1'b0;
		run <= 1'b1;
		wait_cyc(100);
		check(16'(done), 16'h0000);
		run <= 1'b0;
		link <= 1'b1;
		clear_tally();
		miss <= 1'b1;
		scan(4'h8, 16'h0004);
		check(16'(done), 16'h0003);
		check(tally[15:0], 16'h0000);
		check(16'(bnd), 16'h0820);
		check(16'(vdrv), 16'h0020);
		stop_run();
		$display("test boundary done");
		wait_cyc(100);
		check(16'(lvl != 6'h20), 16'h0001);
		for (int i = 0; i < 2; i++)
		begin
			frz <= 1'b1;
			wait_cyc(50);
			check({ovr, und}, 16'h0000);
			keep = lvl;
			eqm <= (i == 0) ? 2'h2 : 2'h3;
			early <= (i == 0);
			wait_cyc(20);
			check(16'(lvl), 16'(keep));
			frz <= 1'b0;
			wait_cyc(105);
			check({ovr, und}, (i == 0) ? 16'h0002 : 16'h0001);
			check(16'(lvl), 16'(keep));
		end
		frz <= 1'b1;
		wait_cyc(50);
		eqm <= 2'h1;
		wait_cyc(2);
		frz <= 1'b0;
		wait_cyc(100);
		check({ovr, und}, 16'h0000);
		check(16'(lvl != keep), 16'h0001);
		$display("test equalizer done");
		report_and_stop();
	end
endmodule
`default_nettype wire
